//--- hdl/baud_if.sv
/*
  Carrier between the bit-rate divider and the line-control logic.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
  logic [15:0] divisor;
  logic sample_tick;
  logic bit_tick;
  modport gen (input divisor, output sample_tick, output bit_tick);
  modport user (output divisor, input sample_tick, input bit_tick);
endinterface
`default_nettype wire

//--- hdl/baud_ticks.sv
/*
  Divider making a one-cycle sample tick every divisor clocks and a
  bit tick on every sixteenth sample tick.
  Assumes divisor is static while ticks matter; zero stops all ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module baud_ticks (
  input wire logic clk,
  input wire logic rst,
  baud_if.gen b
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0] sub;
    logic st;
    logic bt;
  } div_t;

  div_t q;
  div_t d;

  always_comb begin
    d = q;
    d.st = 1'b0;
    d.bt = 1'b0;
    if (b.divisor != 16'h0000) begin
      if (q.cnt >= b.divisor - 16'h0001) begin
        d.cnt = 16'h0000;
        d.st = 1'b1;
        d.sub = q.sub + 4'h1;
        d.bt = (q.sub == uart_lc_pkg::SAMPLES_LAST);
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign b.sample_tick = q.st;
  assign b.bit_tick = q.bt;

endmodule
`default_nettype wire

//--- hdl/uart_lc_pkg.sv
/*
  Shared constants and types of the serial line-control extension block.
  Assumes a 32-bit register port with a 5-bit byte address.
*/
package uart_lc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MODE = 5'h04;
  localparam logic [4:0] OFF_HOLD = 5'h08;
  localparam logic [4:0] OFF_GAP = 5'h0c;
  localparam logic [4:0] OFF_IDLE = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  localparam logic [4:0] OFF_RXDATA = 5'h18;
  localparam logic [4:0] OFF_DIV = 5'h1c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CLEAR_STATUS = 0;
  localparam int CTRL_BEGIN_BREAK = 1;
  localparam int CTRL_END_BREAK = 2;
  localparam int CTRL_ARM_IDLE_WAIT = 3;
  localparam int CTRL_RESTART_IDLE = 4;
  localparam int MODE_SYNC_BIT = 4;
  localparam int MODE_RXEN_BIT = 5;
  localparam int ST_HOLD_FREE = 0;
  localparam int ST_ALL_DONE = 1;
  localparam int ST_RX_READY = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_BREAK = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int ST_CTS = 6;

  // ---------------------------------------------------------------
  // values and counts
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_HANDSHAKE = 4'h2;
  localparam logic [7:0] MIN_BREAK_BITS = 8'h0a;
  localparam logic [7:0] POST_BREAK_BITS = 8'h0c;
  localparam logic [3:0] SAMPLES_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [1:0] END_BRK_ASYNC = 2'h2;
  localparam logic [1:0] END_BRK_SYNC = 2'h1;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_STOP = 3'h2,
    TX_GAP = 3'h6,
    TX_BRK = 3'h7,
    TX_BRK_HIGH = 3'h5
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_STOP = 3'h2,
    RX_BRK_END = 3'h6
  } rx_state_t;

endpackage

//--- hdl/uart_line_ctrl.sv
/*
  Line-control extensions of a serial channel: idle gap, receive idle
  time-out, framing error, break send/detect, RTS/CTS handshake.
  Assumes a one-cycle register port on REF_CLK, 8N1 characters, and a
  receive buffer-full level from a DMA engine on the same clock.
*/
// Function
// - zero gap adds nothing; else line high gap bit periods after stop
// - with gap, hold-free rises only at next start bit
// - with gap, all-done stays low until gap ends
// - gap field reaches 255 bit periods
// - zero idle limit disables time-out; flag stays zero
// - 16-bit down-counter per bit, reloads per character, zero sets flag
// - arm command stops time-out counting until next character
// - restart command reloads limit and counts down at once
// - low stop bit sets framing error mid-stop; status clear clears
// - begin-break drives line low at least one character, after current one
// - further begin-breaks ignored until break ends
// - end-break before minimum length waits for the minimum
// - break taken only while hold free; start clears hold and done
// - lone end-break ignored; byte written while break pending dropped
// - after break line high 12 bits, or gap if longer
// - all-zero character with low stop sets break, not framing
// - end of break: 2/16 bit high async, one sample sync
// - mode value 0x2 enables hardware handshake
// - RTS high while receiver off and buffer full
// - high CTS halts after current character; resumes when low
`timescale 1ns/1ps
`default_nettype none
module uart_line_ctrl (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic TXD,
  input wire logic RXD,
  output logic RTS,
  input wire logic CTS,
  input wire logic RX_BUFFER_FULL
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] divisor;
    logic [3:0] mode;
    logic sync;
    logic rx_en;
    logic [7:0] idle_gap_bits;
    logic [15:0] rx_idle_limit;
    logic [7:0] hold;
    logic hold_full;
    logic brk_pend;
    logic brk_on;
    logic brk_stop;
    uart_lc_pkg::tx_state_t tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [7:0] tx_cnt;
    logic txd_low;
    logic rxd_m;
    logic rxd_s;
    logic cts_m;
    logic cts_s;
    uart_lc_pkg::rx_state_t rx_st;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_ready;
    logic [1:0] hi_cnt;
    logic frame_err;
    logic rx_break_flag;
    logic to_flag;
    logic to_run;
    logic [15:0] to_cnt;
    logic rts;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  baud_if b ();

  baud_ticks u_ticks (
    .clk(REF_CLK),
    .rst(RST),
    .b(b.gen)
  );

  assign b.divisor = q.divisor;

  logic hs;
  logic tx_hold_free;
  logic tx_all_done;
  logic wr_ctrl;
  logic launch;
  logic char_done;
  logic to_hit;
  logic [7:0] post_len;
  logic [1:0] end_thr;

  // ---------------------------------------------------------------
  // flags seen by software and logic
  // ---------------------------------------------------------------
  assign hs = (q.mode == uart_lc_pkg::MODE_HANDSHAKE);
  assign tx_hold_free = !q.hold_full && !q.brk_pend && !q.brk_on;
  assign tx_all_done = (q.tx_st == uart_lc_pkg::TX_IDLE) &&
                       !q.hold_full && !q.brk_pend;
  assign wr_ctrl = WR && (ADDR == uart_lc_pkg::OFF_CTRL);
  assign post_len = (q.idle_gap_bits > uart_lc_pkg::POST_BREAK_BITS) ?
                    q.idle_gap_bits : uart_lc_pkg::POST_BREAK_BITS;
  assign end_thr = q.sync ? uart_lc_pkg::END_BRK_SYNC :
                   uart_lc_pkg::END_BRK_ASYNC;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    launch = 1'b0;
    char_done = 1'b0;
    to_hit = 1'b0;
    d.rxd_m = RXD;
    d.rxd_s = q.rxd_m;
    d.cts_m = CTS;
    d.cts_s = q.cts_m;

    // configuration writes
    if (WR) begin
      case (ADDR)
        uart_lc_pkg::OFF_MODE: begin
          d.mode = WDATA[3:0];
          d.sync = WDATA[uart_lc_pkg::MODE_SYNC_BIT];
          d.rx_en = WDATA[uart_lc_pkg::MODE_RXEN_BIT];
        end
        uart_lc_pkg::OFF_GAP: begin
          d.idle_gap_bits = WDATA[7:0];
        end
        uart_lc_pkg::OFF_IDLE: begin
          d.rx_idle_limit = WDATA[15:0];
        end
        uart_lc_pkg::OFF_DIV: begin
          d.divisor = WDATA[15:0];
        end
        uart_lc_pkg::OFF_HOLD: begin
          if (!q.brk_pend) begin
            d.hold = WDATA[7:0];
            d.hold_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // break commands; simultaneous begin and end is not defined
    if (wr_ctrl && WDATA[uart_lc_pkg::CTRL_BEGIN_BREAK] &&
        tx_hold_free) begin
      d.brk_pend = 1'b1;
    end
    if (wr_ctrl && WDATA[uart_lc_pkg::CTRL_END_BREAK] &&
        (q.brk_pend || q.brk_on)) begin
      d.brk_stop = 1'b1;
    end

    // transmitter, one step per bit period
    if (b.bit_tick) begin
      case (q.tx_st)
        uart_lc_pkg::TX_IDLE: begin
          launch = 1'b1;
        end
        uart_lc_pkg::TX_START: begin
          d.tx_st = uart_lc_pkg::TX_DATA;
          d.tx_bit = 3'h0;
        end
        uart_lc_pkg::TX_DATA: begin
          d.tx_sh = {1'b0, q.tx_sh[7:1]};
          d.tx_bit = q.tx_bit + 3'h1;
          if (q.tx_bit == uart_lc_pkg::LAST_DATA_BIT) begin
            d.tx_st = uart_lc_pkg::TX_STOP;
          end
        end
        uart_lc_pkg::TX_STOP: begin
          if (q.idle_gap_bits != 8'h00) begin
            d.tx_st = uart_lc_pkg::TX_GAP;
            d.tx_cnt = q.idle_gap_bits - 8'h01;
          end else begin
            launch = 1'b1;
          end
        end
        uart_lc_pkg::TX_GAP: begin
          if (q.tx_cnt != 8'h00) begin
            d.tx_cnt = q.tx_cnt - 8'h01;
          end else begin
            launch = 1'b1;
          end
        end
        uart_lc_pkg::TX_BRK: begin
          if (q.tx_cnt != 8'h00) begin
            d.tx_cnt = q.tx_cnt - 8'h01;
          end else if (q.brk_stop) begin
            d.tx_st = uart_lc_pkg::TX_BRK_HIGH;
            d.tx_cnt = post_len - 8'h01;
            d.brk_stop = 1'b0;
          end
        end
        uart_lc_pkg::TX_BRK_HIGH: begin
          if (q.tx_cnt != 8'h00) begin
            d.tx_cnt = q.tx_cnt - 8'h01;
          end else begin
            d.brk_on = 1'b0;
            // a late end-break must not cut the next break short
            d.brk_stop = 1'b0;
            launch = 1'b1;
          end
        end
        default: begin
          d.tx_st = uart_lc_pkg::TX_IDLE;
        end
      endcase
    end

    // pick what follows: break, next byte or idle line
    if (launch) begin
      d.tx_st = uart_lc_pkg::TX_IDLE;
      if (q.brk_pend) begin
        d.tx_st = uart_lc_pkg::TX_BRK;
        d.tx_cnt = uart_lc_pkg::MIN_BREAK_BITS - 8'h01;
        d.brk_pend = 1'b0;
        d.brk_on = 1'b1;
      end else if (q.hold_full && !(hs && q.cts_s)) begin
        d.tx_st = uart_lc_pkg::TX_START;
        d.tx_sh = q.hold;
        d.hold_full = 1'b0;
      end
    end

    d.txd_low = (d.tx_st == uart_lc_pkg::TX_START) ||
                (d.tx_st == uart_lc_pkg::TX_BRK) ||
                ((d.tx_st == uart_lc_pkg::TX_DATA) && !d.tx_sh[0]);

    // status clears come first so a same-cycle event still sets
    if (wr_ctrl && WDATA[uart_lc_pkg::CTRL_CLEAR_STATUS]) begin
      d.frame_err = 1'b0;
      d.rx_break_flag = 1'b0;
    end
    if (RD && (ADDR == uart_lc_pkg::OFF_RXDATA)) begin
      d.rx_ready = 1'b0;
    end

    // receiver at sixteen samples per bit
    if (!q.rx_en) begin
      d.rx_st = uart_lc_pkg::RX_IDLE;
    end else if (b.sample_tick) begin
      case (q.rx_st)
        uart_lc_pkg::RX_IDLE: begin
          if (!q.rxd_s) begin
            d.rx_st = uart_lc_pkg::RX_START;
            d.rx_ph = uart_lc_pkg::SAMPLE_MID;
          end
        end
        uart_lc_pkg::RX_START: begin
          if (q.rx_ph != 4'h0) begin
            d.rx_ph = q.rx_ph - 4'h1;
          end else if (q.rxd_s) begin
            d.rx_st = uart_lc_pkg::RX_IDLE;
          end else begin
            d.rx_st = uart_lc_pkg::RX_DATA;
            d.rx_ph = uart_lc_pkg::SAMPLES_LAST;
            d.rx_bit = 3'h0;
          end
        end
        uart_lc_pkg::RX_DATA: begin
          if (q.rx_ph != 4'h0) begin
            d.rx_ph = q.rx_ph - 4'h1;
          end else begin
            d.rx_sh = {q.rxd_s, q.rx_sh[7:1]};
            d.rx_ph = uart_lc_pkg::SAMPLES_LAST;
            d.rx_bit = q.rx_bit + 3'h1;
            if (q.rx_bit == uart_lc_pkg::LAST_DATA_BIT) begin
              d.rx_st = uart_lc_pkg::RX_STOP;
            end
          end
        end
        uart_lc_pkg::RX_STOP: begin
          if (q.rx_ph != 4'h0) begin
            d.rx_ph = q.rx_ph - 4'h1;
          end else if (q.rxd_s) begin
            d.rx_st = uart_lc_pkg::RX_IDLE;
            d.rx_data = q.rx_sh;
            d.rx_ready = 1'b1;
            char_done = 1'b1;
          end else if (q.rx_sh == 8'h00) begin
            d.rx_st = uart_lc_pkg::RX_BRK_END;
            d.rx_break_flag = 1'b1;
            d.hi_cnt = 2'h0;
          end else begin
            d.rx_st = uart_lc_pkg::RX_IDLE;
            d.frame_err = 1'b1;
          end
        end
        uart_lc_pkg::RX_BRK_END: begin
          if (!q.rxd_s) begin
            d.hi_cnt = 2'h0;
          end else if (q.hi_cnt + 2'h1 >= end_thr) begin
            d.rx_st = uart_lc_pkg::RX_IDLE;
            d.rx_break_flag = 1'b1;
          end else begin
            d.hi_cnt = q.hi_cnt + 2'h1;
          end
        end
        default: begin
          d.rx_st = uart_lc_pkg::RX_IDLE;
        end
      endcase
    end

    // idle time-out counter
    if (b.bit_tick && q.to_run && (q.to_cnt != 16'h0000)) begin
      d.to_cnt = q.to_cnt - 16'h0001;
      if (q.to_cnt == 16'h0001) begin
        to_hit = 1'b1;
        d.to_run = 1'b0;
      end
    end
    if (wr_ctrl && WDATA[uart_lc_pkg::CTRL_ARM_IDLE_WAIT]) begin
      d.to_run = 1'b0;
      d.to_cnt = q.rx_idle_limit;
      d.to_flag = 1'b0;
    end
    if (wr_ctrl && WDATA[uart_lc_pkg::CTRL_RESTART_IDLE]) begin
      d.to_run = 1'b1;
      d.to_cnt = q.rx_idle_limit;
      d.to_flag = 1'b0;
    end
    if (char_done) begin
      d.to_run = 1'b1;
      d.to_cnt = q.rx_idle_limit;
    end
    if (to_hit) begin
      d.to_flag = 1'b1;
    end
    if (q.rx_idle_limit == 16'h0000) begin
      d.to_flag = 1'b0;
      d.to_run = 1'b0;
    end

    // handshake request output
    d.rts = hs && !q.rx_en && RX_BUFFER_FULL;

    // read port, data valid only in the cycle after the strobe
    d.rdata = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        uart_lc_pkg::OFF_MODE: begin
          d.rdata = {26'h0, q.rx_en, q.sync, q.mode};
        end
        uart_lc_pkg::OFF_GAP: begin
          d.rdata = {24'h0, q.idle_gap_bits};
        end
        uart_lc_pkg::OFF_IDLE: begin
          d.rdata = {16'h0, q.rx_idle_limit};
        end
        uart_lc_pkg::OFF_STATUS: begin
          d.rdata[uart_lc_pkg::ST_HOLD_FREE] = tx_hold_free;
          d.rdata[uart_lc_pkg::ST_ALL_DONE] = tx_all_done;
          d.rdata[uart_lc_pkg::ST_RX_READY] = q.rx_ready;
          d.rdata[uart_lc_pkg::ST_FRAME_ERR] = q.frame_err;
          d.rdata[uart_lc_pkg::ST_BREAK] = q.rx_break_flag;
          d.rdata[uart_lc_pkg::ST_TIMEOUT] = q.to_flag;
          d.rdata[uart_lc_pkg::ST_CTS] = q.cts_s;
        end
        uart_lc_pkg::OFF_RXDATA: begin
          d.rdata = {24'h0, q.rx_data};
        end
        uart_lc_pkg::OFF_DIV: begin
          d.rdata = {16'h0, q.divisor};
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // line kept as an active-low flop so reset idles it high
  assign TXD = !q.txd_low;
  assign RTS = q.rts;
  assign RDATA = q.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  property p_gap_zero;
    (q.tx_st == uart_lc_pkg::TX_STOP) && b.bit_tick &&
    (q.idle_gap_bits == 8'h00) |=> (q.tx_st != uart_lc_pkg::TX_GAP);
  endproperty
  a_gap_zero: assert property (p_gap_zero)
    else $error("gap entered with zero gap");

  property p_gap_high;
    (q.tx_st == uart_lc_pkg::TX_GAP) |-> TXD;
  endproperty
  a_gap_high: assert property (p_gap_high)
    else $error("line low during gap");

  property p_gap_hold;
    (q.tx_st == uart_lc_pkg::TX_GAP) && q.hold_full |-> !tx_hold_free;
  endproperty
  a_gap_hold: assert property (p_gap_hold)
    else $error("hold free during gap with byte waiting");

  property p_gap_done;
    (q.tx_st == uart_lc_pkg::TX_GAP) |-> !tx_all_done;
  endproperty
  a_gap_done: assert property (p_gap_done)
    else $error("all done during gap");

  property p_limit_zero;
    (q.rx_idle_limit == 16'h0000) |=> !q.to_flag;
  endproperty
  a_limit_zero: assert property (p_limit_zero)
    else $error("time-out flag with zero limit");

  property p_to_hit;
    b.bit_tick && q.to_run && (q.to_cnt == 16'h0001) &&
    (q.rx_idle_limit != 16'h0000) |=> q.to_flag;
  endproperty
  a_to_hit: assert property (p_to_hit)
    else $error("time-out flag missing at zero");

  property p_frame_src;
    $rose(q.frame_err) |-> $past(q.rx_st) == uart_lc_pkg::RX_STOP;
  endproperty
  a_frame_src: assert property (p_frame_src)
    else $error("framing error outside stop bit");

  property p_brk_min;
    (q.tx_st == uart_lc_pkg::TX_BRK) && (q.tx_cnt != 8'h00)
    |=> (q.tx_st == uart_lc_pkg::TX_BRK) && !TXD;
  endproperty
  a_brk_min: assert property (p_brk_min)
    else $error("break ended early");

  property p_brk_start;
    $rose(q.brk_on) |-> !tx_hold_free && !tx_all_done;
  endproperty
  a_brk_start: assert property (p_brk_start)
    else $error("break start left flags set");

  property p_post_high;
    (q.tx_st == uart_lc_pkg::TX_BRK_HIGH) |-> TXD && q.brk_on;
  endproperty
  a_post_high: assert property (p_post_high)
    else $error("line low after break");

  property p_cts_halt;
    hs && q.cts_s && (q.tx_st == uart_lc_pkg::TX_IDLE) && !q.brk_pend
    |=> (q.tx_st != uart_lc_pkg::TX_START);
  endproperty
  a_cts_halt: assert property (p_cts_halt)
    else $error("character started while CTS high");

  property p_rts;
    hs && !q.rx_en && RX_BUFFER_FULL |=> RTS;
  endproperty
  a_rts: assert property (p_rts)
    else $error("RTS not raised");

  property p_stop_src;
    q.brk_stop |-> q.brk_pend || q.brk_on;
  endproperty
  a_stop_src: assert property (p_stop_src)
    else $error("end-break held with no break");

endmodule
`default_nettype wire

//--- tb/remote_peer.sv
/*
  Remote serial peer: sends 8N1 frames on rxd, decodes txd and times
  its edges in clocks.
  Assumes BIT_CLKS clocks per bit and an idle-high line.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic rts,
  output logic rxd
);
  int cyc = 0;
  int t_fall = 0;
  int t_rise = 0;
  int low_len = 0;
  int high_len = 0;
  int frames = 0;
  logic [7:0] last = 8'h00;
  logic prev = 1'b1;
  initial rxd = 1'b1;
  // -------------------------------------------------------------
  // edge timing on txd
  // -------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev <= txd;
    if (prev && !txd) begin
      t_fall <= cyc;
      high_len <= cyc - t_rise;
    end
    if (!prev && txd) begin
      t_rise <= cyc;
      low_len <= cyc - t_fall;
    end
  end
  // -------------------------------------------------------------
  // decoder, lsb first; a break decodes as 0x00
  // -------------------------------------------------------------
  initial begin
    forever begin
      @(negedge txd);
      repeat (BIT_CLKS * 3 / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        last[i] = txd;
        repeat (BIT_CLKS) @(posedge clk);
      end
      frames++;
      wait (txd);
    end
  end
  // stop may be low to force framing or break cases
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    wait (!rts);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- tb/uart_line_control_extras_tb_top.sv
/*
  Self-checking bench of the line-control block with a remote peer.
  Assumes divisor 1, so one bit is 16 clocks of 40 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_line_control_extras_tb_top;
  localparam int BIT = 16;
  typedef struct packed {
    logic [4:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cts = 1'b0;
  logic full = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic txd;
  logic rxd;
  logic rts;
  int err_total = 0;
  int checks = 0;
  int t0;
  int n0;
  // 0x02 is unaligned: reads 0 whether ignored or seen as ctrl
  row_t rows [7] = '{'{5'h0c, 32'hff, 32'hff}, '{5'h0c, 0, 0},
    '{5'h10, 32'h1ffff, 32'hffff}, '{5'h04, 32'h32, 32'h32},
    '{5'h00, 0, 0}, '{5'h02, 0, 0}, '{5'h1c, 1, 1}};
  always #20 clk = ~clk;
  uart_line_ctrl uart_line_ctrl_inst (.REF_CLK(clk), .RST(rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TXD(txd), .RXD(rxd), .RTS(rts), .CTS(cts),
    .RX_BUFFER_FULL(full));
  remote_peer #(.BIT_CLKS(BIT)) remote_peer_inst (.clk(clk), .txd(txd),
    .rts(rts), .rxd(rxd));
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // one idle edge so a following write never re-drives wr in this step
    @(posedge clk);
  endtask
  task automatic rreg(input logic [4:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic bits(input int n);
    repeat (n * BIT) @(posedge clk);
  endtask
  // bounded poll of one status bit
  task automatic wait_st(input int b, input logic val);
    int n;
    n = 0;
    rreg(5'h14, v);
    while (v[b] !== val && n < 2000) begin
      rreg(5'h14, v);
      n++;
    end
    chk("status", val, v[b]);
  endtask
  task automatic hs(input logic [31:0] m, input logic f, input logic e);
    full <= f;
    wreg(5'h04, m);
    repeat (2) @(posedge clk);
    chk("rts", e, rts);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    chk("txd_rst", 1, txd);
    chk("rts_rst", 0, rts);
    chk("rdata_rst", 0, rdata);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, v);
      chk("reg", rows[i].e, v);
    end
    $display("test regs done");
    wreg(5'h00, 32'h4);
    for (int g = 0; g < 4; g += 3) begin
      wreg(5'h0c, g);
      wreg(5'h08, 32'ha5);
      wait_st(0, 1'b1);
      t0 = remote_peer_inst.t_fall;
      wreg(5'h08, 32'h3c);
      wait_st(0, 1'b1);
      chk("start_gap", (10 + g) * BIT, remote_peer_inst.t_fall - t0);
      t0 = remote_peer_inst.t_fall;
      wait_st(1, 1'b1);
      t0 = remote_peer_inst.cyc - t0;
      chk("done_late", 1, t0 >= (10 + g) * BIT);
      chk("byte", 8'h3c, remote_peer_inst.last);
    end
    $display("test gap done");
    wreg(5'h0c, 0);
    n0 = remote_peer_inst.frames;
    wreg(5'h08, 32'h55);
    wait_st(0, 1'b1);
    wreg(5'h00, 32'h2);
    wreg(5'h00, 32'h2);
    wreg(5'h08, 32'h77);
    wreg(5'h00, 32'h4);
    bits(12);
    rreg(5'h14, v);
    chk("brk_flags", 0, v[1:0]);
    wreg(5'h08, 32'h99);
    wait_st(0, 1'b1);
    chk("brk_len", 1, remote_peer_inst.low_len >= 10 * BIT);
    chk("post_brk", 1, remote_peer_inst.high_len >= 12 * BIT);
    wait_st(1, 1'b1);
    chk("frames", n0 + 3, remote_peer_inst.frames);
    chk("byte", 8'h99, remote_peer_inst.last);
    $display("test break done");
    wreg(5'h04, 32'h20);
    remote_peer_inst.send(8'h3a, 1'b0);
    rreg(5'h14, v);
    chk("frame", 2'b01, v[4:3]);
    wreg(5'h00, 32'h1);
    rreg(5'h14, v);
    chk("clear", 0, v[4:3]);
    remote_peer_inst.send(8'h00, 1'b0);
    rreg(5'h14, v);
    chk("rx_brk", 2'b10, v[4:3]);
    wreg(5'h00, 32'h1);
    wreg(5'h10, 0);
    remote_peer_inst.send(8'h41, 1'b1);
    bits(20);
    rreg(5'h14, v);
    chk("to_off", 4'b0001, v[5:2]);
    rreg(5'h18, v);
    chk("rx_byte", 8'h41, v);
    wreg(5'h10, 5);
    remote_peer_inst.send(8'h41, 1'b1);
    rreg(5'h14, v);
    chk("to_early", 0, v[5]);
    bits(6);
    rreg(5'h14, v);
    chk("to_hit", 1, v[5]);
    wreg(5'h00, 32'h10);
    wreg(5'h00, 32'h8);
    bits(10);
    rreg(5'h14, v);
    chk("to_arm", 0, v[5]);
    wreg(5'h00, 32'h10);
    bits(7);
    rreg(5'h14, v);
    chk("to_again", 1, v[5]);
    wreg(5'h00, 32'h8);
    remote_peer_inst.send(8'h41, 1'b1);
    bits(6);
    rreg(5'h14, v);
    chk("to_char", 1, v[5]);
    $display("test rx done");
    hs(32'h02, 1'b1, 1'b1);
    hs(32'h22, 1'b1, 1'b0);
    hs(32'h02, 1'b0, 1'b0);
    hs(32'h00, 1'b1, 1'b0);
    cts <= 1'b1;
    hs(32'h02, 1'b0, 1'b0);
    n0 = remote_peer_inst.frames;
    wreg(5'h08, 32'h11);
    bits(20);
    chk("cts_hold", n0, remote_peer_inst.frames);
    rreg(5'h14, v);
    chk("cts_st", 1, v[6]);
    cts <= 1'b0;
    bits(14);
    chk("cts_go", n0 + 1, remote_peer_inst.frames);
    chk("byte", 8'h11, remote_peer_inst.last);
    $display("test handshake done");
    end_sim();
  end
endmodule
`default_nettype wire
